// [src/cell_protection_fsm.sv]
// protection state machine of a one-cell battery guard
`timescale 1ns/1ps
`default_nettype none
module cell_protection_fsm
  import cell_protection_pkg::*;
#(
  parameter int unsigned OC_DETECT = OC_DETECT_CYCLES,
  parameter int unsigned OC_RELEASE = OC_RELEASE_CYCLES,
  parameter int unsigned OD_DETECT = OD_DETECT_CYCLES,
  parameter int unsigned OD_RELEASE = OD_RELEASE_CYCLES,
  parameter int unsigned DOC_DETECT = DOC_DETECT_CYCLES,
  parameter int unsigned DOC_RELEASE = DOC_RELEASE_CYCLES,
  parameter int unsigned SHORT_DETECT = SHORT_DETECT_CYCLES,
  parameter int unsigned COC_DETECT = COC_DETECT_CYCLES,
  parameter int unsigned COC_RELEASE = COC_RELEASE_CYCLES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic above_overcharge_in,
  input wire logic above_overcharge_release_in,
  input wire logic below_overdischarge_in,
  input wire logic at_overdischarge_release_in,
  input wire logic sense_above_doc_in,
  input wire logic sense_above_short_in,
  input wire logic sense_below_coc_in,
  input wire logic sense_below_charger_in,
  input wire logic sense_near_ground_in,
  input wire logic charger_over_detect_in,
  input wire logic charger_below_release_in,
  input wire logic cell_zero_volt_in,
  input wire logic opt_power_down_in,
  input wire logic opt_zero_volt_charge_in,
  output logic charge_switch_on_out,
  output logic discharge_switch_on_out,
  output logic sense_pullup_on_out,
  output logic sense_pulldown_on_out,
  output logic sleep_out,
  output logic [2:0] state_out
);

  //////////////////////////////////////////////////////////////////////
  prot_state_t state_r, state_nxt;
  logic [TIMER_W-1:0] oc_cnt_r, ocr_cnt_r, od_cnt_r, odr_cnt_r;
  logic [TIMER_W-1:0] doc_cnt_r, sc_cnt_r, coc_cnt_r, cocr_cnt_r;
  logic oc_done, ocr_done, od_done, odr_done, doc_done, sc_done, coc_done, cocr_done;
  logic coc_block_r, charger_ov_r;
  logic oc_cond, ocr_cond, od_cond, odr_cond, doc_cond, sc_cond;
  logic zero_volt_block;

  // saturating timer step: restart on lapse, hold at target
  function automatic logic [TIMER_W-1:0] tick(input logic cond, input logic [TIMER_W-1:0] cnt,
                                              input int unsigned lim);
    if (!cond)
      tick = '0;
    else if (cnt >= lim[TIMER_W-1:0])
      tick = cnt;
    else
      tick = cnt + 1'b1;
  endfunction

  // discharge path open only without a discharge fault
  function automatic logic discharge_allowed(input prot_state_t st);
    discharge_allowed = (st == ST_NORMAL) || (st == ST_OVERCHARGE);
  endfunction

  // faults that hold the sense pin low through the pull-down
  function automatic logic discharge_fault(input prot_state_t st);
    discharge_fault = (st == ST_DISCH_OVERCURRENT) || (st == ST_SHORT_CIRCUIT);
  endfunction

  assign oc_cond = (state_r == ST_NORMAL) && above_overcharge_in;
  assign od_cond = (state_r == ST_NORMAL) && below_overdischarge_in;
  assign doc_cond = (state_r == ST_NORMAL) && sense_above_doc_in && !sense_above_short_in;
  assign sc_cond = (state_r == ST_NORMAL) && sense_above_short_in;
  assign ocr_cond = (state_r == ST_OVERCHARGE) &&
                    (sense_above_doc_in ? !above_overcharge_in : !above_overcharge_release_in);
  assign odr_cond = (state_r == ST_OVERDISCHARGE) && !opt_power_down_in &&
                    !sense_below_charger_in && at_overdischarge_release_in;
  assign zero_volt_block = cell_zero_volt_in && !opt_zero_volt_charge_in;

  assign oc_done = (oc_cnt_r >= OC_DETECT[TIMER_W-1:0]);
  assign ocr_done = (ocr_cnt_r >= OC_RELEASE[TIMER_W-1:0]);
  assign od_done = (od_cnt_r >= OD_DETECT[TIMER_W-1:0]);
  assign odr_done = (odr_cnt_r >= OD_RELEASE[TIMER_W-1:0]);
  assign doc_done = (doc_cnt_r >= DOC_DETECT[TIMER_W-1:0]);
  assign sc_done = (sc_cnt_r >= SHORT_DETECT[TIMER_W-1:0]);
  assign coc_done = (coc_cnt_r >= COC_DETECT[TIMER_W-1:0]);
  assign cocr_done = (cocr_cnt_r >= COC_RELEASE[TIMER_W-1:0]);

  //////////////////////////////////////////////////////////////////////
  // timers restart on lapse
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      oc_cnt_r <= '0;
    else
      oc_cnt_r <= tick(oc_cond, oc_cnt_r, OC_DETECT);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      ocr_cnt_r <= '0;
    else
      ocr_cnt_r <= tick(ocr_cond, ocr_cnt_r, OC_RELEASE);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      od_cnt_r <= '0;
    else
      od_cnt_r <= tick(od_cond, od_cnt_r, OD_DETECT);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      odr_cnt_r <= '0;
    else
      odr_cnt_r <= tick(odr_cond, odr_cnt_r, OD_RELEASE);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      doc_cnt_r <= '0;
    else
      doc_cnt_r <= tick(doc_cond, doc_cnt_r, DOC_DETECT);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      sc_cnt_r <= '0;
    else
      sc_cnt_r <= tick(sc_cond, sc_cnt_r, SHORT_DETECT);
  end

  //////////////////////////////////////////////////////////////////////
  // charge overcurrent runs beside the main states, it only gates charging
  // charge overcurrent detect
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      coc_cnt_r <= '0;
    else
      coc_cnt_r <= tick(!coc_block_r && sense_below_coc_in, coc_cnt_r, COC_DETECT);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      cocr_cnt_r <= '0;
    else
      cocr_cnt_r <= tick(coc_block_r && !sense_below_coc_in, cocr_cnt_r, COC_RELEASE);
  end

  // set and clear never meet: each is gated by the opposite flag level
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      coc_block_r <= 1'b0;
    else if (!coc_block_r && coc_done)
      coc_block_r <= 1'b1;
    else if (coc_block_r && cocr_done)
      coc_block_r <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      charger_ov_r <= 1'b0;
    else if (charger_over_detect_in)
      charger_ov_r <= 1'b1;
    else if (charger_below_release_in)
      charger_ov_r <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_NORMAL: begin
        // short outranks overcurrent, discharge faults outrank charge faults
        // enter short state
        if (sc_done)
          state_nxt = ST_SHORT_CIRCUIT;
        else if (doc_done)
          state_nxt = ST_DISCH_OVERCURRENT;
        else if (od_done)
          state_nxt = ST_OVERDISCHARGE;
        else if (oc_done)
          state_nxt = ST_OVERCHARGE;
      end
      ST_OVERCHARGE: begin
        if (ocr_done)
          state_nxt = ST_NORMAL;
      end
      ST_OVERDISCHARGE: begin
        if (sense_below_charger_in && !below_overdischarge_in)
          state_nxt = ST_NORMAL;
        else if (opt_power_down_in && at_overdischarge_release_in)
          state_nxt = ST_NORMAL;
        else if (odr_done)
          state_nxt = ST_NORMAL;
      end
      ST_DISCH_OVERCURRENT, ST_SHORT_CIRCUIT: begin
        if (sense_near_ground_in)
          state_nxt = ST_NORMAL;
      end
      default: state_nxt = ST_NORMAL;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      state_r <= ST_NORMAL;
    else
      state_r <= state_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  // charge switch gating
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      charge_switch_on_out <= 1'b0;
    else
      charge_switch_on_out <= (state_nxt != ST_OVERCHARGE) && !coc_block_r &&
                              !charger_ov_r && !zero_volt_block;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      discharge_switch_on_out <= 1'b0;
    else
      discharge_switch_on_out <= discharge_allowed(state_nxt);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      sense_pullup_on_out <= 1'b0;
    else
      sense_pullup_on_out <= (state_nxt == ST_OVERDISCHARGE);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      sense_pulldown_on_out <= 1'b0;
    else
      sense_pulldown_on_out <= discharge_fault(state_nxt);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      sleep_out <= 1'b0;
    else
      sleep_out <= (state_nxt == ST_OVERDISCHARGE) && opt_power_down_in;
  end

  // code follows the next state so it lines up with the switches
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      state_out <= '0;
    else
      state_out <= state_nxt;
  end

endmodule // cell_protection_fsm
`default_nettype wire

// [src/cell_protection_pkg.sv]
// constants and types shared by the cell protection state machine
package cell_protection_pkg;
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
  // delays in their own units, nominal figures
  localparam int unsigned OVERCHARGE_DETECT_DELAY_MS = 1000;
  localparam int unsigned OVERCHARGE_RELEASE_DELAY_MS = 2;
  localparam int unsigned OVERDISCHARGE_DETECT_DELAY_MS = 115;
  localparam int unsigned OVERDISCHARGE_RELEASE_DELAY_MS = 2;
  localparam int unsigned DISCHARGE_OVERCURRENT_DELAY_MS = 10;
  localparam int unsigned DISCHARGE_OVERCURRENT_RELEASE_MS = 2;
  localparam int unsigned SHORT_DETECT_DELAY_US = 360;
  localparam int unsigned CHARGE_OVERCURRENT_DELAY_MS = 10;
  localparam int unsigned CHARGE_OVERCURRENT_RELEASE_MS = 2;
  localparam int unsigned CYCLES_PER_MS = 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned CYCLES_PER_US = 1_000 / CLK_PERIOD_NS;
  localparam int unsigned OC_DETECT_CYCLES = OVERCHARGE_DETECT_DELAY_MS * CYCLES_PER_MS;
  localparam int unsigned OC_RELEASE_CYCLES = OVERCHARGE_RELEASE_DELAY_MS * CYCLES_PER_MS;
  localparam int unsigned OD_DETECT_CYCLES = OVERDISCHARGE_DETECT_DELAY_MS * CYCLES_PER_MS;
  localparam int unsigned OD_RELEASE_CYCLES = OVERDISCHARGE_RELEASE_DELAY_MS * CYCLES_PER_MS;
  localparam int unsigned DOC_DETECT_CYCLES = DISCHARGE_OVERCURRENT_DELAY_MS * CYCLES_PER_MS;
  localparam int unsigned DOC_RELEASE_CYCLES = DISCHARGE_OVERCURRENT_RELEASE_MS * CYCLES_PER_MS;
  localparam int unsigned SHORT_DETECT_CYCLES = SHORT_DETECT_DELAY_US * CYCLES_PER_US;
  localparam int unsigned COC_DETECT_CYCLES = CHARGE_OVERCURRENT_DELAY_MS * CYCLES_PER_MS;
  localparam int unsigned COC_RELEASE_CYCLES = CHARGE_OVERCURRENT_RELEASE_MS * CYCLES_PER_MS;
  localparam int unsigned TIMER_W = 27;
  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_OVERCHARGE,
    ST_OVERDISCHARGE,
    ST_DISCH_OVERCURRENT,
    ST_SHORT_CIRCUIT
  } prot_state_t;
endpackage : cell_protection_pkg

// [verification/cell_protection_sva.sv]
// assertions on the protection state machine ports
`timescale 1ns/1ps
`default_nettype none
module cell_protection_sva #(
  parameter int unsigned SHORT_DETECT = 6,
  parameter int unsigned DOC_DETECT = 8
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic sense_above_doc_in,
  input wire logic sense_above_short_in,
  input wire logic sense_near_ground_in,
  input wire logic charger_over_detect_in,
  input wire logic charge_switch_on_out,
  input wire logic discharge_switch_on_out,
  input wire logic sense_pullup_on_out,
  input wire logic sense_pulldown_on_out,
  input wire logic [2:0] state_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic up_r;
  logic [31:0] sc_r;
  logic [31:0] dc_r;
  // outputs only settle one edge after reset
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      up_r <= 1'b0;
      sc_r <= 32'h0;
      dc_r <= 32'h0;
    end else begin
      up_r <= 1'b1;
      sc_r <= (sense_above_short_in && state_out == 3'h0) ? sc_r + 32'h1 : 32'h0;
      dc_r <= (sense_above_doc_in && state_out == 3'h0) ? dc_r + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_short_ripe;
    sense_above_short_in && state_out == 3'h0 && sc_r == 32'(SHORT_DETECT);
  endsequence
  property p_short_trip;
    s_short_ripe |=> state_out == 3'h4 && !discharge_switch_on_out;
  endproperty
  a_short_trip: assert property (p_short_trip) else $error("short not taken");
  property p_short_early;
    state_out == 3'h0 && sc_r < 32'(SHORT_DETECT) |=> state_out != 3'h4;
  endproperty
  a_short_early: assert property (p_short_early) else $error("short too early");
  property p_doc_early;
    state_out == 3'h0 && dc_r < 32'(DOC_DETECT) |=> state_out != 3'h3;
  endproperty
  a_doc_early: assert property (p_doc_early) else $error("overcurrent too early");
  property p_normal_outs;
    up_r && state_out == 3'h0 |-> discharge_switch_on_out && !sense_pullup_on_out
      && !sense_pulldown_on_out;
  endproperty
  a_normal_outs: assert property (p_normal_outs) else $error("normal outputs");
  property p_oc_outs;
    state_out == 3'h1 |-> !sense_pullup_on_out && !sense_pulldown_on_out;
  endproperty
  a_oc_outs: assert property (p_oc_outs) else $error("overcharge resistors");
  property p_od_outs;
    state_out == 3'h2 |-> sense_pullup_on_out && !sense_pulldown_on_out
      && !discharge_switch_on_out;
  endproperty
  a_od_outs: assert property (p_od_outs) else $error("overdischarge outputs");
  property p_release;
    (state_out == 3'h3 || state_out == 3'h4) && sense_near_ground_in
      && !sense_above_doc_in && !sense_above_short_in |=> state_out == 3'h0
      && sense_pulldown_on_out == 1'b0;
  endproperty
  a_release: assert property (p_release) else $error("no release");
  property p_charger_ov;
    charger_over_detect_in |-> ##2 !charge_switch_on_out;
  endproperty
  a_charger_ov: assert property (p_charger_ov) else $error("charger overvoltage");
endmodule // cell_protection_sva
`default_nettype wire

// [verification/cell_load_model.sv]
// cell, charger and load seen through the sense pin
`timescale 1ns/1ps
`default_nettype none
module cell_load_model (
  input wire logic load_on_in,
  input wire logic charger_on_in,
  input wire logic pulldown_on_in,
  output logic near_ground_out,
  output logic below_charger_out
);
  assign near_ground_out = pulldown_on_in && !load_on_in && !charger_on_in;
  assign below_charger_out = charger_on_in;
endmodule // cell_load_model
`default_nettype wire

// [verification/cell_protection_fsm_bench.sv]
// self-checking bench for the cell protection state machine
`timescale 1ns/1ps
`default_nettype none
module cell_protection_fsm_bench;
  localparam int unsigned SD = 6;
  localparam int unsigned DD = 8;
  localparam int unsigned RD = 5;
  localparam int unsigned CD = 7;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic above_overcharge_in = 1'b0;
  logic above_overcharge_release_in = 1'b0;
  logic below_overdischarge_in = 1'b0;
  logic at_overdischarge_release_in = 1'b1;
  logic sense_above_doc_in = 1'b0;
  logic sense_above_short_in = 1'b0;
  logic sense_below_coc_in = 1'b0;
  logic charger_over_detect_in = 1'b0;
  logic charger_below_release_in = 1'b1;
  logic cell_zero_volt_in = 1'b0;
  logic opt_power_down_in = 1'b0;
  logic opt_zero_volt_charge_in = 1'b1;
  logic load = 1'b0;
  logic chg = 1'b0;
  logic sense_below_charger_in, sense_near_ground_in, charge_switch_on_out, sleep_out;
  logic discharge_switch_on_out, sense_pullup_on_out, sense_pulldown_on_out;
  logic [2:0] state_out;
  logic [7:0] got;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int len;
  int lim;
  assign got = {charge_switch_on_out, discharge_switch_on_out, sense_pullup_on_out,
    sense_pulldown_on_out, sleep_out, state_out};
  cell_protection_fsm #(.OC_DETECT(12), .OC_RELEASE(RD), .OD_DETECT(10), .OD_RELEASE(RD),
    .DOC_DETECT(DD), .DOC_RELEASE(RD), .SHORT_DETECT(SD), .COC_DETECT(CD),
    .COC_RELEASE(RD)) dut_u (.*);
  cell_load_model load_u (.load_on_in(load), .charger_on_in(chg),
    .pulldown_on_in(sense_pulldown_on_out), .near_ground_out(sense_near_ground_in),
    .below_charger_out(sense_below_charger_in));
  always #5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] want(input logic [2:0] st, input logic cs, input logic sl);
    return {cs, st < 3'h2, st == 3'h2, st > 3'h2, sl, st};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
    n_tests++;
    if ((g & m) !== (e & m)) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g & m, e & m);
    end
  endtask
  task automatic ed(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic complete_run();
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // long enough for every scenario with ample margin
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    len = $urandom(21920);
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    ed(2);
    chk(got, want(3'h0, 1'b1, 1'b0), 8'hFF);
    for (int k = 0; k < 2; k++) begin
      lim = k ? DD : SD;
      for (int i = 0; i < 8; i++) begin
        len = (i < 2) ? lim + i : $urandom_range(lim + 2, 1);
        @(posedge clk_in);
        sense_above_short_in <= (k == 0);
        sense_above_doc_in <= 1'b1;
        load <= 1'b1;
        ed(len);
        chk(got, want((len > lim) ? 3'h4 - k[2:0] : 3'h0, 1'b1, 1'b0), 8'h7F);
        @(posedge clk_in);
        sense_above_short_in <= 1'b0;
        sense_above_doc_in <= 1'b0;
        load <= 1'b0;
        ed(3);
        chk(got, want(3'h0, 1'b1, 1'b0), 8'hFF);
      end
    end
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_in);
      opt_power_down_in <= (m < 2);
      at_overdischarge_release_in <= 1'b0;
      below_overdischarge_in <= 1'b1;
      ed(10);
      chk(got, want(3'h0, 1'b1, 1'b0), 8'h07);
      ed(1);
      chk(got, want(3'h2, 1'b0, m < 2), 8'h7F);
      @(posedge clk_in);
      below_overdischarge_in <= 1'b0;
      chg <= (m == 0);
      at_overdischarge_release_in <= (m != 0);
      ed(m < 2 ? 2 : RD - 1);
      chk(got, want(m < 2 ? 3'h0 : 3'h2, 1'b0, 1'b0), 8'h3F);
      @(posedge clk_in);
      chg <= 1'b0;
      at_overdischarge_release_in <= 1'b1;
      ed(4);
      chk(got, want(3'h0, 1'b1, 1'b0), 8'hFF);
    end
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_in);
      above_overcharge_in <= 1'b1;
      above_overcharge_release_in <= 1'b1;
      ed(12);
      chk(got, want(3'h0, 1'b1, 1'b0), 8'h07);
      ed(1);
      chk(got, want(3'h1, 1'b0, 1'b0), 8'hFF);
      @(posedge clk_in);
      above_overcharge_in <= 1'b0;
      sense_above_doc_in <= j[0];
      ed(RD + 3);
      chk(got, want(j ? 3'h0 : 3'h1, j[0], 1'b0), 8'hFF);
      @(posedge clk_in);
      above_overcharge_release_in <= 1'b0;
      sense_above_doc_in <= 1'b0;
      ed(RD + 3);
      chk(got, want(3'h0, 1'b1, 1'b0), 8'hFF);
    end
    for (int g = 0; g < 3; g++) begin
      @(posedge clk_in);
      charger_over_detect_in <= (g == 0);
      charger_below_release_in <= (g != 0);
      sense_below_coc_in <= (g == 1);
      cell_zero_volt_in <= (g == 2);
      opt_zero_volt_charge_in <= 1'b0;
      ed(g == 1 ? CD + 2 : 2);
      chk(got, want(3'h0, 1'b0, 1'b0), 8'h80);
      @(posedge clk_in);
      charger_over_detect_in <= 1'b0;
      charger_below_release_in <= 1'b1;
      sense_below_coc_in <= 1'b0;
      opt_zero_volt_charge_in <= 1'b1;
      ed(g == 1 ? RD + 3 : 3);
      chk(got, want(3'h0, 1'b1, 1'b0), 8'h80);
    end
    complete_run();
  end
endmodule // cell_protection_fsm_bench
bind cell_protection_fsm cell_protection_sva #(.SHORT_DETECT(SHORT_DETECT),
  .DOC_DETECT(DOC_DETECT)) sva_u (.*);
`default_nettype wire
